// >>> rtl/power_start_and_mode_sequencer.v
// power start handshake and power mode sequencer
// assumes instruction completion strobes are one-cycle pulses after writeback
// and that a clock gate holds a stopped clock high when its enable is low
//
// Overview of operation
// (R1) power switch, carrier detect or wake alarm starts the handshake from off.
// (R2) on a start cause drive the power-on indicator active.
// (R3) sample both battery inputs three RTC periods after indicator goes active.
// (R4) either battery input low: drop indicator one RTC period later, stay off.
// (R5) both high: drop indicator four periods later, enable main power, start.
// (R6) fullspeed runs processor clock at 33 MHz, bus clock at same rate.
// (R7) fullspeed is the default mode and is restored after any reset.
// (R8) standby holds core clocks high except timers and interrupt logic.
// (R9) standby keeps all peripheral units running so DMA continues.
// (R10) standby entry waits core bus idle, then stops core clock only.
// (R11) any interrupt, timer included, returns standby to fullspeed.
// (R12) suspend stops peripheral bus clock, keeps wake logic and retained state.
// (R13) suspend entry starts DRAM self-refresh, waits bus idle, stops core clock.
// (R14) suspend holds until an interrupt is accepted, then returns to fullspeed.
// (R15) hibernate stops clocks to every unit and both bus clock outputs.
// (R16) in hibernate only 32.768 kHz logic, wake timer and start detect run.
// (R17) hibernate instruction starts self-refresh, drops main power, enters reset.
// (R18) start and battery inputs are synchronised to the RTC before use.
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"
module power_start_and_mode_sequencer (
  // clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // real-time clock and start causes
  input wire rtc_clk_i,
  input wire power_switch_i,
  input wire carrier_detect_i,
  input wire wakeup_alarm_i,
  // battery interlocks
  input wire battery_inhibit_in_i,
  input wire battery_lock_in_i,
  // core events
  input wire standby_instr_i,
  input wire suspend_instr_i,
  input wire hibernate_instr_i,
  input wire core_bus_idle_i,
  input wire interrupt_i,
  input wire int_accept_i,
  // external power handshake
  output reg power_on_indicator_o,
  output reg main_power_enable_o,
  output reg core_reset_o,
  // clock enables
  output reg processor_clock_en_o,
  output reg timer_clock_en_o,
  output reg int_clock_en_o,
  output reg peripheral_bus_clock_en_o,
  output reg core_bus_clock_out_en_o,
  output reg pll_en_o,
  output reg wake_logic_en_o,
  output reg [1:0] bus_clk_ratio_o,
  // memory and status
  output reg dram_self_refresh_o,
  output reg [1:0] power_mode_o
);

  // ==========================================================
  // rtc clock sampling
  // ==========================================================
  wire [5:0] raw_in;
  wire [5:0] sync_in;
  reg rtc_prev;
  wire rtc_tick;

  assign raw_in = {rtc_clk_i, power_switch_i, carrier_detect_i,
                   wakeup_alarm_i, battery_inhibit_in_i, battery_lock_in_i};

  sync_two_flop #(
    .WIDTH(6)
  ) u_sync (
    .clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .async_i(raw_in),
    .sync_o(sync_in)
  );

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rtc_prev <= 1'b0;
    end else begin
      rtc_prev <= sync_in[5];
    end
  end

  // one pulse per rtc rising edge
  assign rtc_tick = sync_in[5] & ~rtc_prev;

  // ==========================================================
  // inputs captured in the rtc time base
  // ==========================================================
  reg rtc_cause;

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rtc_cause <= 1'b0;
    end else if (rtc_tick) begin
      rtc_cause <= sync_in[4] | sync_in[3] | sync_in[2]; // R18
    end
  end

  // ==========================================================
  // start handshake state machine
  // ==========================================================
  reg [2:0] st;
  reg [2:0] next_st;
  reg [2:0] tick_cnt;
  reg [2:0] next_tick_cnt;
  reg [2:0] md;
  reg [2:0] next_md;
  wire batt_ok;
  wire go_hib;

  // battery levels as they stand at the judging tick
  assign batt_ok = sync_in[1] & sync_in[0]; // R3 R18
  assign go_hib = (st == `ST_ON) && (md == `MD_FULL) && hibernate_instr_i;

  always @* begin
    next_st = st;
    next_tick_cnt = tick_cnt;
    case (st)
      `ST_OFF: begin
        next_tick_cnt = `TICK_CNT_RST;
        if (rtc_tick && rtc_cause) begin
          next_st = `ST_ANNOUNCE; // R1
        end
      end
      `ST_ANNOUNCE: begin
        if (rtc_tick) begin
          if (tick_cnt == `ANNOUNCE_TICKS - 3'h1) begin
            next_tick_cnt = `TICK_CNT_RST;
            if (batt_ok) begin
              next_st = `ST_ACCEPT; // R3
            end else begin
              next_st = `ST_REJECT; // R3
            end
          end else begin
            next_tick_cnt = tick_cnt + 3'h1;
          end
        end
      end
      `ST_REJECT: begin
        if (rtc_tick) begin
          if (tick_cnt == `REJECT_TICKS - 3'h1) begin
            next_tick_cnt = `TICK_CNT_RST;
            next_st = `ST_OFF; // R4
          end else begin
            next_tick_cnt = tick_cnt + 3'h1;
          end
        end
      end
      `ST_ACCEPT: begin
        if (rtc_tick) begin
          if (tick_cnt == `ACCEPT_TICKS - 3'h1) begin
            next_tick_cnt = `TICK_CNT_RST;
            next_st = `ST_ON; // R5
          end else begin
            next_tick_cnt = tick_cnt + 3'h1;
          end
        end
      end
      `ST_ON: begin
        next_tick_cnt = `TICK_CNT_RST;
        if (go_hib) begin
          next_st = `ST_OFF; // R17
        end
      end
      default: begin
        next_st = `ST_OFF;
        next_tick_cnt = `TICK_CNT_RST;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= `ST_OFF;
      tick_cnt <= `TICK_CNT_RST;
    end else begin
      st <= next_st;
      tick_cnt <= next_tick_cnt;
    end
  end

  // ==========================================================
  // power mode state machine
  // ==========================================================
  always @* begin
    next_md = md;
    case (md)
      `MD_FULL: begin
        if (st == `ST_ON) begin
          if (hibernate_instr_i) begin
            next_md = `MD_HIB; // R17
          end else if (suspend_instr_i) begin
            next_md = `MD_SUSP_WAIT; // R13
          end else if (standby_instr_i) begin
            next_md = `MD_STBY_WAIT; // R10
          end
        end
      end
      `MD_STBY_WAIT: begin
        if (interrupt_i) begin
          next_md = `MD_FULL; // R11
        end else if (core_bus_idle_i) begin
          next_md = `MD_STBY; // R10
        end
      end
      `MD_STBY: begin
        if (interrupt_i) begin
          next_md = `MD_FULL; // R11
        end
      end
      `MD_SUSP_WAIT: begin
        if (int_accept_i) begin
          next_md = `MD_FULL; // R14
        end else if (core_bus_idle_i) begin
          next_md = `MD_SUSP; // R13
        end
      end
      `MD_SUSP: begin
        if (int_accept_i) begin
          next_md = `MD_FULL; // R14
        end
      end
      `MD_HIB: begin
        // a successful start brings the core back in fullspeed
        if (st == `ST_ACCEPT && next_st == `ST_ON) begin
          next_md = `MD_FULL; // R7
        end
      end
      default: begin
        next_md = `MD_FULL;
      end
    endcase
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      md <= `MD_FULL; // R7
    end else begin
      md <= next_md;
    end
  end

  // ==========================================================
  // external power handshake outputs
  // ==========================================================
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_on_indicator_o <= 1'b0;
      main_power_enable_o <= 1'b0;
      // core held in reset whenever main power is not granted
      core_reset_o <= 1'b1;
    end else begin
      // R2 R4 R5
      power_on_indicator_o <= (next_st == `ST_ANNOUNCE) ||
                              (next_st == `ST_REJECT) ||
                              (next_st == `ST_ACCEPT);
      main_power_enable_o <= (next_st == `ST_ON); // R5 R17
      core_reset_o <= (next_st != `ST_ON); // R17
    end
  end

  // ==========================================================
  // clock enables
  // ==========================================================
  wire run;

  assign run = (next_st == `ST_ON);

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      processor_clock_en_o <= 1'b0;
    end else begin
      // R8 R10 R13 R15
      processor_clock_en_o <= run && (next_md != `MD_STBY) &&
                              (next_md != `MD_SUSP) && (next_md != `MD_HIB);
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timer_clock_en_o <= 1'b0;
      int_clock_en_o <= 1'b0;
      pll_en_o <= 1'b0;
      core_bus_clock_out_en_o <= 1'b0;
      wake_logic_en_o <= 1'b0;
    end else begin
      timer_clock_en_o <= run && (next_md != `MD_HIB); // R8 R15
      int_clock_en_o <= run && (next_md != `MD_HIB); // R8 R15
      pll_en_o <= run && (next_md != `MD_HIB); // R10 R15
      core_bus_clock_out_en_o <= run && (next_md != `MD_HIB); // R10 R15
      // rtc domain start detection never stops; this gates the other wake sources
      wake_logic_en_o <= run && (next_md != `MD_HIB); // R12 R16
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      peripheral_bus_clock_en_o <= 1'b0;
    end else begin
      // R9 R12 R15
      peripheral_bus_clock_en_o <= run && (next_md != `MD_SUSP) &&
                                   (next_md != `MD_HIB);
    end
  end

  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bus_clk_ratio_o <= `BUS_CLK_RATIO_RST;
    end else begin
      bus_clk_ratio_o <= `BUS_CLK_RATIO; // R6
    end
  end

  // ==========================================================
  // dram self-refresh
  // ==========================================================
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dram_self_refresh_o <= 1'b0;
    end else if (go_hib) begin
      dram_self_refresh_o <= 1'b1; // R17
    end else if (next_md == `MD_SUSP_WAIT && md == `MD_FULL) begin
      dram_self_refresh_o <= 1'b1; // R13
    end else if (next_md == `MD_FULL && md != `MD_FULL) begin
      dram_self_refresh_o <= 1'b0; // R14
    end
  end

  // ==========================================================
  // reported mode
  // ==========================================================
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_mode_o <= `MODE_RST; // R7
    end else begin
      case (next_md)
        `MD_FULL: begin
          power_mode_o <= `MODE_FULLSPEED;
        end
        `MD_STBY_WAIT, `MD_STBY: begin
          power_mode_o <= `MODE_STANDBY;
        end
        `MD_SUSP_WAIT, `MD_SUSP: begin
          power_mode_o <= `MODE_SUSPEND;
        end
        `MD_HIB: begin
          power_mode_o <= `MODE_HIBERNATE; // R16
        end
        default: begin
          power_mode_o <= `MODE_FULLSPEED;
        end
      endcase
    end
  end

endmodule // power_start_and_mode_sequencer

// >>> rtl/pwr_seq_defs.vh
// constants for the power start and power mode sequencer
// assumes a 250 MHz reference clock and a 32.768 kHz real-time clock input
`ifndef PWR_SEQ_DEFS_VH
`define PWR_SEQ_DEFS_VH

// clock rates
`define REF_CLK_MHZ 250
`define RTC_CLK_HZ 32768
`define CORE_CLK_MHZ 33

// start handshake timing, in real-time clock periods
`define ANNOUNCE_TICKS 3'h3
`define REJECT_TICKS 3'h1
`define ACCEPT_TICKS 3'h4
`define TICK_CNT_RST 3'h0

// start handshake states
`define ST_OFF 3'h0
`define ST_ANNOUNCE 3'h1
`define ST_REJECT 3'h2
`define ST_ACCEPT 3'h3
`define ST_ON 3'h4

// power mode states
`define MD_FULL 3'h0
`define MD_STBY_WAIT 3'h1
`define MD_STBY 3'h2
`define MD_SUSP_WAIT 3'h3
`define MD_SUSP 3'h4
`define MD_HIB 3'h5

// reported power mode codes
`define MODE_FULLSPEED 2'h0
`define MODE_STANDBY 2'h1
`define MODE_SUSPEND 2'h2
`define MODE_HIBERNATE 2'h3

// core to bus clock ratio in fullspeed
`define BUS_CLK_RATIO 2'h1

// reset values
`define MODE_RST `MODE_FULLSPEED
`define BUS_CLK_RATIO_RST `BUS_CLK_RATIO

`endif

// >>> rtl/sync_two_flop.v
// two-flop synchroniser, one stage pair per bit
// assumes asynchronous inputs and a single destination clock
`timescale 1ns/1ns
module sync_two_flop #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk_i,
  input wire nrst_i,
  // data
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg meta;
      reg stable;
      always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          meta <= 1'b0;
          stable <= 1'b0;
        end else begin
          meta <= async_i[g];
          stable <= meta;
        end
      end
      assign sync_o[g] = stable;
    end
  endgenerate

endmodule // sync_two_flop

// >>> test/ext_supply_model.sv
// external supply circuit and battery interlock stand-in
// assumes the bench sets interlock levels; rtc sped up to keep runs short
`timescale 1ns/1ns
module ext_supply_model (
  // bench control
  input wire inh_ok_i,
  input wire lock_ok_i,
  // toward the sequencer
  output reg rtc_clk_o,
  output wire battery_inhibit_in_o,
  output wire battery_lock_in_o,
  output integer ticks_o
);
  assign battery_inhibit_in_o = inh_ok_i;
  assign battery_lock_in_o = lock_ok_i;
  // free-running oscillator, 11 reference periods long, rising 1 ns before a reference edge
  initial begin
    rtc_clk_o = 1'b0;
    ticks_o = 0;
    #3;
    forever begin
      #22 rtc_clk_o = ~rtc_clk_o;
      if (rtc_clk_o) ticks_o = ticks_o + 1;
    end
  end
endmodule // ext_supply_model

// >>> test/power_start_and_mode_sequencer_properties.sv
// port-level properties of the power start and mode sequencer
// assumes binding onto the sequencer top, one reference clock
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"
module power_start_and_mode_sequencer_properties (
  // clock and reset
  input wire ref_clk_i,
  input wire nrst_i,
  // core events
  input wire standby_instr_i,
  input wire suspend_instr_i,
  input wire hibernate_instr_i,
  input wire core_bus_idle_i,
  input wire interrupt_i,
  input wire int_accept_i,
  // outputs watched
  input wire power_on_indicator_o,
  input wire main_power_enable_o,
  input wire core_reset_o,
  input wire processor_clock_en_o,
  input wire timer_clock_en_o,
  input wire peripheral_bus_clock_en_o,
  input wire core_bus_clock_out_en_o,
  input wire dram_self_refresh_o,
  input wire [1:0] power_mode_o,
  input wire [1:0] bus_clk_ratio_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // ==========================================
  // mode request sequences
  sequence s_full;
    main_power_enable_o && power_mode_o == `MODE_FULLSPEED;
  endsequence
  sequence s_stby_req;
    s_full ##0 (standby_instr_i && !suspend_instr_i && !hibernate_instr_i);
  endsequence
  sequence s_susp_req;
    s_full ##0 (suspend_instr_i && !hibernate_instr_i);
  endsequence
  sequence s_hib_req;
    s_full ##0 hibernate_instr_i;
  endsequence
  // ==========================================
  // assertions
  a_stby_entry: assert property (s_stby_req |=> power_mode_o == `MODE_STANDBY && peripheral_bus_clock_en_o)
    else $error("standby entry wrong");
  a_stby_stop: assert property (power_mode_o == `MODE_STANDBY && core_bus_idle_i && !interrupt_i
    |=> !processor_clock_en_o && timer_clock_en_o && core_bus_clock_out_en_o)
    else $error("standby clock stop wrong");
  a_stby_wake: assert property (power_mode_o == `MODE_STANDBY && interrupt_i
    |=> power_mode_o == `MODE_FULLSPEED && processor_clock_en_o)
    else $error("standby wake wrong");
  a_susp_entry: assert property (s_susp_req |=> power_mode_o == `MODE_SUSPEND && dram_self_refresh_o)
    else $error("suspend entry wrong");
  a_susp_stop: assert property (power_mode_o == `MODE_SUSPEND && core_bus_idle_i && !int_accept_i
    |=> !processor_clock_en_o && !peripheral_bus_clock_en_o)
    else $error("suspend clock stop wrong");
  a_susp_wake: assert property (power_mode_o == `MODE_SUSPEND && int_accept_i
    |=> power_mode_o == `MODE_FULLSPEED && !dram_self_refresh_o)
    else $error("suspend wake wrong");
  a_hib_entry: assert property (s_hib_req |=> !main_power_enable_o && core_reset_o && dram_self_refresh_o)
    else $error("hibernate entry wrong");
  a_hib_clocks: assert property (power_mode_o == `MODE_HIBERNATE |-> !processor_clock_en_o
    && !peripheral_bus_clock_en_o && !core_bus_clock_out_en_o)
    else $error("clock running in hibernate");
  a_accept_edge: assert property ($rose(main_power_enable_o) |-> $fell(power_on_indicator_o))
    else $error("mains not with indicator fall");
  a_ind_holds: assert property ($rose(power_on_indicator_o) |-> power_on_indicator_o[*8])
    else $error("indicator too short");
  a_ind_no_mains: assert property (power_on_indicator_o |-> !main_power_enable_o)
    else $error("indicator with mains on");
  a_ratio_const: assert property (bus_clk_ratio_o == `BUS_CLK_RATIO)
    else $error("bus clock ratio wrong");
endmodule // power_start_and_mode_sequencer_properties

// >>> test/tb_power_start_and_mode_sequencer.sv
// self-checking bench for the power start and mode sequencer
// assumes the supply model and the property checker alongside
`timescale 1ns/1ns
`include "pwr_seq_defs.vh"
module tb_power_start_and_mode_sequencer;
  reg ref_clk_i, nrst_i, power_switch_i, carrier_detect_i, wakeup_alarm_i, inh_ok, lock_ok;
  reg standby_instr_i, suspend_instr_i, hibernate_instr_i, core_bus_idle_i, interrupt_i, int_accept_i;
  wire rtc_clk_i, battery_inhibit_in_i, battery_lock_in_i, power_on_indicator_o, main_power_enable_o;
  wire core_reset_o, processor_clock_en_o, timer_clock_en_o, int_clock_en_o, peripheral_bus_clock_en_o;
  wire core_bus_clock_out_en_o, pll_en_o, wake_logic_en_o, dram_self_refresh_o;
  wire [1:0] bus_clk_ratio_o, power_mode_o;
  integer ticks, n_errors, num_checks, cycles;
  power_start_and_mode_sequencer i_power_start_and_mode_sequencer (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .rtc_clk_i(rtc_clk_i), .power_switch_i(power_switch_i),
    .carrier_detect_i(carrier_detect_i), .wakeup_alarm_i(wakeup_alarm_i),
    .battery_inhibit_in_i(battery_inhibit_in_i), .battery_lock_in_i(battery_lock_in_i),
    .standby_instr_i(standby_instr_i), .suspend_instr_i(suspend_instr_i), .hibernate_instr_i(hibernate_instr_i),
    .core_bus_idle_i(core_bus_idle_i), .interrupt_i(interrupt_i), .int_accept_i(int_accept_i),
    .power_on_indicator_o(power_on_indicator_o), .main_power_enable_o(main_power_enable_o),
    .core_reset_o(core_reset_o), .processor_clock_en_o(processor_clock_en_o), .timer_clock_en_o(timer_clock_en_o),
    .int_clock_en_o(int_clock_en_o), .peripheral_bus_clock_en_o(peripheral_bus_clock_en_o),
    .core_bus_clock_out_en_o(core_bus_clock_out_en_o), .pll_en_o(pll_en_o), .wake_logic_en_o(wake_logic_en_o),
    .bus_clk_ratio_o(bus_clk_ratio_o), .dram_self_refresh_o(dram_self_refresh_o), .power_mode_o(power_mode_o));
  ext_supply_model i_ext_supply_model (.inh_ok_i(inh_ok), .lock_ok_i(lock_ok), .rtc_clk_o(rtc_clk_i),
    .battery_inhibit_in_o(battery_inhibit_in_i), .battery_lock_in_o(battery_lock_in_i), .ticks_o(ticks));
  // ==========================================
  // checking and closing
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %s exp %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic summarize;
    if (n_errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========================================
  // stimulus tasks
  task automatic wait_ind(input logic lvl);
    int n;
    n = 0;
    while (power_on_indicator_o !== lvl && n < 300) begin
      @(negedge ref_clk_i);
      n = n + 1;
    end
    if (n == 300) n_errors = n_errors + 1;
  endtask
  task automatic start(input int cause, input logic ok);
    int t0;
    logic [1:0] bad;
    bad = $urandom_range(2, 0);
    @(negedge ref_clk_i);
    inh_ok = ok | bad[0];
    lock_ok = ok | bad[1];
    {wakeup_alarm_i, carrier_detect_i, power_switch_i} = 3'h1 << cause;
    wait_ind(1'b1);
    t0 = ticks;
    {wakeup_alarm_i, carrier_detect_i, power_switch_i} = 3'h0;
    wait_ind(1'b0);
    check("ticks", ticks - t0, ok ? 32'h7 : 32'h4);
    @(negedge ref_clk_i);
    check("mains", main_power_enable_o, ok);
  endtask
  task automatic pulse(input int which);
    @(negedge ref_clk_i);
    {hibernate_instr_i, suspend_instr_i, standby_instr_i} = 3'h1 << which;
    @(negedge ref_clk_i);
    {hibernate_instr_i, suspend_instr_i, standby_instr_i} = 3'h0;
  endtask
  // ==========================================
  // clock, timeout, sequence
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      summarize;
    end
  end
  initial begin
    {n_errors, num_checks, cycles} = {32'h0, 32'h0, 32'h0};
    {nrst_i, power_switch_i, carrier_detect_i, wakeup_alarm_i, inh_ok, lock_ok} = 6'h3;
    {standby_instr_i, suspend_instr_i, hibernate_instr_i, core_bus_idle_i, interrupt_i, int_accept_i} = 6'h0;
    void'($urandom(32'h36fe_c167));
    repeat (20) @(negedge ref_clk_i);
    check("mode", power_mode_o, `MODE_RST);
    check("ratio", bus_clk_ratio_o, `BUS_CLK_RATIO_RST);
    check("reset", {main_power_enable_o, core_reset_o, power_on_indicator_o}, 3'h2);
    nrst_i = 1'b1;
    for (int i = 0; i < 4; i++) start(i % 3, i == 3);
    check("full", {power_mode_o, processor_clock_en_o, core_reset_o}, 4'h2);
    repeat ($urandom_range(5, 1)) @(negedge ref_clk_i);
    pulse(0);
    check("stby", {power_mode_o, processor_clock_en_o, peripheral_bus_clock_en_o}, 4'h7);
    core_bus_idle_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check("stby_stop", {processor_clock_en_o, timer_clock_en_o, int_clock_en_o, pll_en_o}, 4'h7);
    interrupt_i = 1'b1;
    @(negedge ref_clk_i);
    interrupt_i = 1'b0;
    check("stby_wake", {power_mode_o, processor_clock_en_o}, 3'h1);
    core_bus_idle_i = 1'b0;
    pulse(1);
    check("susp", {power_mode_o, dram_self_refresh_o}, 3'h5);
    pulse(0);
    check("refused", power_mode_o, `MODE_SUSPEND);
    core_bus_idle_i = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    check("susp_stop", {processor_clock_en_o, peripheral_bus_clock_en_o, wake_logic_en_o}, 3'h1);
    int_accept_i = 1'b1;
    @(negedge ref_clk_i);
    int_accept_i = 1'b0;
    check("susp_wake", {power_mode_o, dram_self_refresh_o}, 3'h0);
    pulse(2);
    check("hib", {power_mode_o, main_power_enable_o, core_reset_o, dram_self_refresh_o}, 5'h1b);
    check("hib_clk", {processor_clock_en_o, peripheral_bus_clock_en_o, core_bus_clock_out_en_o}, 3'h0);
    check("hib_off", {wake_logic_en_o, pll_en_o, timer_clock_en_o, int_clock_en_o}, 4'h0);
    start(2, 1'b1);
    check("hib_exit", power_mode_o, `MODE_FULLSPEED);
    pulse(0);
    nrst_i = 1'b0;
    @(negedge ref_clk_i);
    check("rst_mode", {power_mode_o, main_power_enable_o, core_reset_o}, 4'h1);
    nrst_i = 1'b1;
    start(1, 1'b1);
    check("rst_full", {power_mode_o, processor_clock_en_o}, 3'h1);
    summarize;
  end
endmodule // tb_power_start_and_mode_sequencer
bind power_start_and_mode_sequencer power_start_and_mode_sequencer_properties i_props (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .standby_instr_i(standby_instr_i), .suspend_instr_i(suspend_instr_i),
  .hibernate_instr_i(hibernate_instr_i), .core_bus_idle_i(core_bus_idle_i), .interrupt_i(interrupt_i),
  .int_accept_i(int_accept_i), .power_on_indicator_o(power_on_indicator_o),
  .main_power_enable_o(main_power_enable_o), .core_reset_o(core_reset_o),
  .processor_clock_en_o(processor_clock_en_o), .timer_clock_en_o(timer_clock_en_o),
  .peripheral_bus_clock_en_o(peripheral_bus_clock_en_o), .core_bus_clock_out_en_o(core_bus_clock_out_en_o),
  .dram_self_refresh_o(dram_self_refresh_o), .power_mode_o(power_mode_o), .bus_clk_ratio_o(bus_clk_ratio_o));
